/* File: bench/otppv_ctrl_asserts.sv */
// Port-level checks for the OTP program/verify controller
`timescale 1ns/1ps
module otppv_ctrl_asserts #(
    parameter int LOW_CYC = 12500
) (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   s_axi_arvalid_i,
    input wire logic                   s_axi_arready_o,
    input wire logic                   s_axi_rvalid_o,
    input wire logic                   s_axi_rready_i,
    input wire logic                   s_axi_bvalid_o,
    input wire logic                   s_axi_bready_i,
    input wire logic [1:0]             s_axi_bresp_o,
    input wire otppv_pkg::otppv_pins_t pins_o
);
    // ---------------------------------------------------------------
    // Pulse phase counters
    // ---------------------------------------------------------------
    localparam int HIGH_MIN = 1250;
    logic [15:0] low_cnt;
    logic [15:0] hi_cnt;
    wire  [3:0]  sel = {pins_o.port2_bit7, pins_o.port2_bit6, pins_o.port3_bit7, pins_o.port3_bit6};
    wire         pp  = pins_o.latch_program_pulse_pin;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt <= 16'h0000;
            hi_cnt  <= 16'h0000;
        end else begin
            low_cnt <= pp ? 16'h0000 : low_cnt + 16'h0001;
            // Saturate so the long idle gap cannot wrap
            hi_cnt  <= !pp ? 16'h0000 : ((hi_cnt == 16'hFFFF) ? hi_cnt : hi_cnt + 16'h0001);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_pulse_fall;
        $fell(pp);
    endsequence
    sequence s_pulse_rise;
        $rose(pp);
    endsequence

    a_pulse_low_width: assert property (s_pulse_rise |-> low_cnt == 16'(LOW_CYC))
        else $error("program pulse low time wrong");
    a_pulse_high_gap: assert property (s_pulse_fall |-> hi_cnt >= HIGH_MIN)
        else $error("program pulse high gap too short");
    a_pulse_under_vpp: assert property (!pp |-> pins_o.vpp_en && pins_o.dev_rst && !pins_o.program_store_strobe)
        else $error("pulse without program levels");
    a_vpp_before_pulse: assert property (s_pulse_fall |-> $past(pins_o.vpp_en, 8))
        else $error("supply not set up before pulse");
    a_prog_modes: assert property (pins_o.vpp_en |-> sel inside {4'hB, 4'hA, 4'hF, 4'hC, 4'h5})
        else $error("supply on with undefined selectors");
    a_read_release: assert property ((sel[3:2] == 2'h0) |-> !pins_o.port0_oe && pp && pins_o.external_access_supply_pin)
        else $error("read mode levels wrong");
    a_hold_in_pulse: assert property (!pp |-> $stable(pins_o.addr) && $stable(pins_o.port0_out) && $stable(sel))
        else $error("address or data moved during pulse");
    a_osc_half_min: assert property ($changed(pins_o.osc) |=> !$changed(pins_o.osc) [*8])
        else $error("device clock too fast");
    a_osc_half_max: assert property ($changed(pins_o.osc) |-> ##[1:12] $changed(pins_o.osc))
        else $error("device clock too slow or stopped");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
        else $error("read answer dropped");
    a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write answer dropped");
endmodule

/* File: bench/otppv_ctrl_test.sv */
// Self-checking bench for the OTP program/verify controller
`timescale 1ns/1ps
module otppv_ctrl_test;
    localparam int         LOW_T = 20;
    localparam logic [7:0] MAKER = 8'h6D; // Arbitrary identity value
    localparam logic [7:0] PART  = 8'h2E; // Arbitrary identity value
    logic                   clk_i, rst_i = 1'b1;
    logic [7:0]             s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, port0_i, dev_p0;
    logic [31:0]            s_axi_wdata_i = 32'h00000000, s_axi_rdata_o;
    logic                   s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic                   s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic                   s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]             s_axi_bresp_o, s_axi_rresp_o;
    otppv_pkg::otppv_pins_t pins_o;
    int                     n_mismatch = 0;
    int                     num_checks = 0;

    otppv_ctrl #(.LOW_CYC(LOW_T)) uut (.clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
        .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .port0_i, .pins_o);
    otppv_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_dev (.pins_i(pins_o), .port0_o(dev_p0));
    assign port0_i = pins_o.port0_oe ? pins_o.port0_out : dev_p0;

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // ---------------------------------------------------------------
    // Bus, check and finish tasks
    // ---------------------------------------------------------------
    task automatic close_out();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_i);
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        s_axi_bready_i  <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o) break;
        end
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        if (n == 200) begin
            n_mismatch++;
            close_out();
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_i);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i  <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o) break;
        end
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        if (n == 200) begin
            n_mismatch++;
            close_out();
        end
    endtask

    // Start one operation, refuse a second go, wait for done and clear it
    task automatic run_op(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d, output logic [7:0] rd);
        logic [1:0]  r;
        logic [31:0] st;
        int          n;
        axi_wr(otppv_pkg::OFS_ADDR, {16'h0000, a}, r);
        axi_wr(otppv_pkg::OFS_WDATA, {24'h000000, d}, r);
        axi_wr(otppv_pkg::OFS_CTRL, {28'h0000000, 1'b1, op}, r);
        chk({30'h00000000, r}, {30'h00000000, otppv_pkg::RESP_OKAY});
        axi_wr(otppv_pkg::OFS_CTRL, {28'h0000000, 1'b1, op}, r);
        chk({30'h00000000, r}, {30'h00000000, otppv_pkg::RESP_SLV});
        for (n = 0; n < 8000; n++) begin
            axi_rd(otppv_pkg::OFS_STATUS, st, r);
            if (st[otppv_pkg::ST_DONE] === 1'b1) break;
        end
        if (n == 8000) begin
            n_mismatch++;
            close_out();
        end
        rd = st[15:8];
        axi_wr(otppv_pkg::OFS_STATUS, 32'h00000002, r);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [7:0]  b;
        logic [1:0]  r;
        logic [31:0] v;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({27'h0000000, pins_o.dev_rst, pins_o.program_store_strobe, pins_o.latch_program_pulse_pin,
             pins_o.external_access_supply_pin, pins_o.vpp_en}, 32'h00000016);
        axi_rd(otppv_pkg::OFS_STATUS, v, r);
        chk({30'h00000000, v[1:0]}, 32'h00000000);
        axi_rd(8'h10, v, r);
        chk(v, 32'h00000000);
        chk({30'h00000000, r}, {30'h00000000, otppv_pkg::RESP_SLV});
        axi_wr(8'h14, 32'h00000001, r);
        chk({30'h00000000, r}, {30'h00000000, otppv_pkg::RESP_SLV});
        run_op(otppv_pkg::OP_CODE, 16'h0103, 8'h5A, b);
        axi_rd(otppv_pkg::OFS_ADDR, v, r);
        chk(v, 32'h00000103);
        axi_rd(otppv_pkg::OFS_CTRL, v, r);
        chk(v, {29'h00000000, otppv_pkg::OP_CODE});
        axi_rd(otppv_pkg::OFS_WDATA, v, r);
        chk(v, 32'h0000005A);
        run_op(otppv_pkg::OP_VERIFY, 16'h0103, 8'h00, b);
        chk({24'h000000, b}, 32'h0000005A);
        run_op(otppv_pkg::OP_SIG, 16'h0030, 8'h00, b);
        chk({24'h000000, b}, {24'h000000, MAKER});
        run_op(otppv_pkg::OP_SIG, 16'h0031, 8'h00, b);
        chk({24'h000000, b}, {24'h000000, PART});
        run_op(otppv_pkg::OP_ENC, 16'h0003, 8'h0F, b);
        run_op(otppv_pkg::OP_VERIFY, 16'h0103, 8'h00, b);
        chk({24'h000000, b}, 32'h000000AA);
        run_op(otppv_pkg::OP_LOCK1, 16'h0000, 8'h00, b);
        run_op(otppv_pkg::OP_CODE, 16'h0103, 8'h00, b);
        run_op(otppv_pkg::OP_VERIFY, 16'h0103, 8'h00, b);
        chk({24'h000000, b}, 32'h000000AA);
        run_op(otppv_pkg::OP_LOCK2, 16'h0000, 8'h00, b);
        run_op(otppv_pkg::OP_VERIFY, 16'h0103, 8'h00, b);
        chk({24'h000000, b}, 32'h000000FF);
        run_op(otppv_pkg::OP_LOCK3, 16'h0000, 8'h00, b);
        close_out();
    end
endmodule

bind otppv_ctrl otppv_ctrl_asserts #(.LOW_CYC(LOW_CYC)) u_chk (.clk_i, .rst_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .pins_o);

/* File: bench/otppv_dev_model.sv */
// Behavioural model of the OTP microcontroller in program/verify mode
`timescale 1ns/1ps
module otppv_dev_model #(
    parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary identity value
    parameter logic [7:0] PART_CODE  = 8'h3C  // Arbitrary identity value
) (
    input  wire otppv_pkg::otppv_pins_t pins_i,
    output logic [7:0]                  port0_o
);
    logic [7:0]  code_mem [logic [13:0]];
    logic [7:0]  enc_tab [64];
    logic [2:0]  lock_bits = 3'h0;
    int          n_pulse   = 0;
    wire  [3:0]  sel = {pins_i.port2_bit7, pins_i.port2_bit6, pins_i.port3_bit7, pins_i.port3_bit6};
    wire  [13:0] loc = pins_i.addr[13:0];
    wire  [7:0]  din = pins_i.port0_oe ? pins_i.port0_out : 8'hFF;

    initial foreach (enc_tab[i]) enc_tab[i] = 8'hFF;

    always @(negedge pins_i.vpp_en) n_pulse = 0;
    always @(posedge pins_i.latch_program_pulse_pin) begin
        if (pins_i.vpp_en && pins_i.dev_rst && !pins_i.program_store_strobe) n_pulse = n_pulse + 1;
        if (n_pulse == otppv_pkg::N_PULSES) begin
            case (sel)
                4'hB: if (lock_bits == 3'h0) code_mem[loc] = din;
                4'hA: if (lock_bits == 3'h0) enc_tab[loc[5:0]] = din;
                4'hF: lock_bits[0] = 1'b1;
                4'hC: lock_bits[1] = 1'b1;
                4'h5: lock_bits[2] = 1'b1;
                default: ;
            endcase
        end
    end

    // Only low levels are driven; a released port reads as the pull-ups
    always @* begin
        port0_o = 8'hFF;
        if (pins_i.dev_rst && !pins_i.program_store_strobe && !pins_i.vpp_en && pins_i.latch_program_pulse_pin) begin
            if (sel == 4'h3 && lock_bits[2:1] == 2'h0)
                port0_o = ~((code_mem.exists(loc) ? code_mem[loc] : 8'hFF) ^ enc_tab[loc[5:0]]);
            else if (sel == 4'h0 && loc == 14'h0030) port0_o = MAKER_CODE;
            else if (sel == 4'h0 && loc == 14'h0031) port0_o = PART_CODE;
        end
    end
endmodule

/* File: hw/otppv_ctrl.sv */
// Programmer-side controller driving an OTP microcontroller's program/verify pins
`timescale 1ns/1ps
module otppv_ctrl #(
    parameter int LOW_CYC = otppv_pkg::LOW_CYC
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic [7:0]         s_axi_awaddr_i,
    input  wire logic               s_axi_awvalid_i,
    output logic                    s_axi_awready_o,
    input  wire logic [31:0]        s_axi_wdata_i,
    input  wire logic [3:0]         s_axi_wstrb_i,
    input  wire logic               s_axi_wvalid_i,
    output logic                    s_axi_wready_o,
    output logic [1:0]              s_axi_bresp_o,
    output logic                    s_axi_bvalid_o,
    input  wire logic               s_axi_bready_i,
    input  wire logic [7:0]         s_axi_araddr_i,
    input  wire logic               s_axi_arvalid_i,
    output logic                    s_axi_arready_o,
    output logic [31:0]             s_axi_rdata_o,
    output logic [1:0]              s_axi_rresp_o,
    output logic                    s_axi_rvalid_o,
    input  wire logic               s_axi_rready_i,
    input  wire logic [7:0]         port0_i,
    output otppv_pkg::otppv_pins_t  pins_o
);

    // ---------------------------------------------------------------
    // Elaboration check
    // ---------------------------------------------------------------
    if (LOW_CYC < 1 || LOW_CYC >= (1 << otppv_pkg::CNT_W)) begin : g_chk
        $error("LOW_CYC does not fit the pulse counter");
    end

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        otppv_pkg::otppv_state_t   fsm;
        otppv_pkg::otppv_op_t      op;
        logic [otppv_pkg::CNT_W-1:0] cnt;
        logic [2:0]                npulse;
        logic [4:0]                osc_cnt;
        logic [15:0]               addr;
        logic [7:0]                wdata;
        logic [7:0]                rdata;
        logic                      done;
        logic                      aw_have;
        logic [7:0]                aw_addr;
        logic                      w_have;
        logic [31:0]               w_data;
        logic [3:0]                w_strb;
        logic                      awready;
        logic                      wready;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [31:0]               rdata_bus;
        logic [1:0]                rresp;
        otppv_pkg::otppv_pins_t    pins;
    } otppv_st_t;

    otppv_st_t st_reg;
    otppv_st_t st_next;

    localparam logic [15:0] LOW_CNT   = LOW_CYC[15:0] - 16'h0001;
    localparam logic [15:0] SETUP_CNT = 16'(otppv_pkg::SETUP_CYC - 1);
    localparam logic [15:0] HIGH_CNT  = 16'(otppv_pkg::HIGH_CYC - 1);
    localparam logic [15:0] HOLD_CNT  = 16'(otppv_pkg::HOLD_CYC - 1);
    localparam logic [15:0] READ_CNT  = 16'(otppv_pkg::READ_CYC - 1);
    localparam logic [4:0]  OSC_CNT   = 5'(otppv_pkg::OSC_HALF - 1);
    localparam logic [2:0]  LAST_PULSE = 3'(otppv_pkg::N_PULSES - 1);

    // Idle levels: device held in reset, nothing driven on port 0
    function automatic otppv_pkg::otppv_pins_t idle_pins(input logic osc);
        otppv_pkg::otppv_pins_t p;
        p                            = '0;
        p.dev_rst                    = 1'b1;
        p.latch_program_pulse_pin    = 1'b1;
        p.external_access_supply_pin = 1'b1;
        p.osc                        = osc;
        return p;
    endfunction

    // Selector levels per operation
    function automatic logic [3:0] sel_of(input otppv_pkg::otppv_op_t op);
        case (op)
            otppv_pkg::OP_CODE:   sel_of = 4'hB;
            otppv_pkg::OP_ENC:    sel_of = 4'hA;
            otppv_pkg::OP_LOCK1:  sel_of = 4'hF;
            otppv_pkg::OP_LOCK2:  sel_of = 4'hC;
            otppv_pkg::OP_LOCK3:  sel_of = 4'h5;
            otppv_pkg::OP_VERIFY: sel_of = 4'h3;
            default:              sel_of = 4'h0;
        endcase
    endfunction

    logic is_prog;
    logic ctrl_go;
    logic clr_done;
    logic [3:0] sel;

    always_comb begin
        st_next  = st_reg;
        is_prog  = st_reg.op inside {otppv_pkg::OP_CODE, otppv_pkg::OP_ENC,
                                     otppv_pkg::OP_LOCK1, otppv_pkg::OP_LOCK2,
                                     otppv_pkg::OP_LOCK3};
        sel      = sel_of(st_reg.op);
        ctrl_go  = 1'b0;
        clr_done = 1'b0;

        // -----------------------------------------------------------
        // Device oscillator, free running
        // -----------------------------------------------------------
        if (st_reg.osc_cnt == OSC_CNT) begin
            st_next.osc_cnt  = '0;
            st_next.pins.osc = ~st_reg.pins.osc;
        end else begin
            st_next.osc_cnt = st_reg.osc_cnt + 5'h01;
        end

        // -----------------------------------------------------------
        // AXI4-Lite write channel
        // -----------------------------------------------------------
        if (s_axi_awvalid_i && st_reg.awready) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = s_axi_awaddr_i;
            st_next.awready = 1'b0;
        end
        if (s_axi_wvalid_i && st_reg.wready) begin
            st_next.w_have = 1'b1;
            st_next.w_data = s_axi_wdata_i;
            st_next.w_strb = s_axi_wstrb_i;
            st_next.wready = 1'b0;
        end
        if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
            st_next.aw_have = 1'b0;
            st_next.w_have  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = otppv_pkg::RESP_OKAY;
            if (st_reg.aw_addr[7:2] == otppv_pkg::OFS_CTRL[7:2]) begin
                if (st_reg.w_strb[0] && st_reg.w_data[otppv_pkg::CTRL_GO]) begin
                    if (st_reg.fsm == otppv_pkg::S_IDLE) begin
                        ctrl_go = 1'b1;
                    end else begin
                        st_next.bresp = otppv_pkg::RESP_SLV;
                    end
                end
            end else if (st_reg.aw_addr[7:2] == otppv_pkg::OFS_ADDR[7:2]) begin
                if (st_reg.w_strb[0]) begin
                    st_next.addr[7:0] = st_reg.w_data[7:0];
                end
                if (st_reg.w_strb[1]) begin
                    st_next.addr[15:8] = st_reg.w_data[15:8];
                end
            end else if (st_reg.aw_addr[7:2] == otppv_pkg::OFS_WDATA[7:2]) begin
                if (st_reg.w_strb[0]) begin
                    st_next.wdata = st_reg.w_data[7:0];
                end
            end else if (st_reg.aw_addr[7:2] == otppv_pkg::OFS_STATUS[7:2]) begin
                clr_done = st_reg.w_strb[0] && st_reg.w_data[otppv_pkg::ST_DONE];
            end else begin
                st_next.bresp = otppv_pkg::RESP_SLV;
            end
        end
        if (st_reg.bvalid && s_axi_bready_i) begin
            st_next.bvalid  = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready  = 1'b1;
        end
        if (clr_done) begin
            st_next.done = 1'b0;
        end

        // -----------------------------------------------------------
        // AXI4-Lite read channel
        // -----------------------------------------------------------
        if (s_axi_arvalid_i && st_reg.arready) begin
            st_next.arready   = 1'b0;
            st_next.rvalid    = 1'b1;
            st_next.rresp     = otppv_pkg::RESP_OKAY;
            st_next.rdata_bus = '0;
            if (s_axi_araddr_i[7:2] == otppv_pkg::OFS_CTRL[7:2]) begin
                st_next.rdata_bus[2:0] = st_reg.op;
            end else if (s_axi_araddr_i[7:2] == otppv_pkg::OFS_ADDR[7:2]) begin
                st_next.rdata_bus[15:0] = st_reg.addr;
            end else if (s_axi_araddr_i[7:2] == otppv_pkg::OFS_WDATA[7:2]) begin
                st_next.rdata_bus[7:0] = st_reg.wdata;
            end else if (s_axi_araddr_i[7:2] == otppv_pkg::OFS_STATUS[7:2]) begin
                st_next.rdata_bus[otppv_pkg::ST_BUSY] = st_reg.fsm != otppv_pkg::S_IDLE;
                st_next.rdata_bus[otppv_pkg::ST_DONE] = st_reg.done;
                st_next.rdata_bus[otppv_pkg::ST_RD_LSB +: 8] = st_reg.rdata;
            end else begin
                st_next.rresp = otppv_pkg::RESP_SLV;
            end
        end
        if (st_reg.rvalid && s_axi_rready_i) begin
            st_next.rvalid  = 1'b0;
            st_next.arready = 1'b1;
        end

        // -----------------------------------------------------------
        // Pin sequencer
        // -----------------------------------------------------------
        if (st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - 16'h0001;
        end
        case (st_reg.fsm)
            otppv_pkg::S_IDLE: begin
                if (ctrl_go && st_reg.w_data[2:0] != otppv_pkg::OP_NONE) begin
                    st_next.op  = otppv_pkg::otppv_op_t'(st_reg.w_data[2:0]);
                    st_next.fsm = otppv_pkg::S_SETUP;
                    st_next.cnt = SETUP_CNT;
                    st_next.npulse = '0;
                end
            end
            otppv_pkg::S_SETUP: begin
                // Levels, address and data settle before the first pulse
                st_next.pins.program_store_strobe = 1'b0;
                st_next.pins.dev_rst              = 1'b1;
                {st_next.pins.port2_bit7, st_next.pins.port2_bit6,
                 st_next.pins.port3_bit7, st_next.pins.port3_bit6} = sel;
                st_next.pins.addr = st_reg.addr;
                if (is_prog) begin
                    st_next.pins.vpp_en    = 1'b1;
                    st_next.pins.port0_out = st_reg.wdata;
                    st_next.pins.port0_oe  = 1'b1;
                end else begin
                    st_next.pins.port0_oe  = 1'b0;
                end
                if (st_reg.cnt == '0) begin
                    if (is_prog) begin
                        st_next.fsm = otppv_pkg::S_LOW;
                        st_next.cnt = LOW_CNT;
                        st_next.pins.latch_program_pulse_pin = 1'b0;
                    end else begin
                        st_next.fsm = otppv_pkg::S_READ;
                        st_next.cnt = READ_CNT;
                    end
                end
            end
            otppv_pkg::S_LOW: begin
                if (st_reg.cnt == '0) begin
                    st_next.pins.latch_program_pulse_pin = 1'b1;
                    st_next.fsm = otppv_pkg::S_HIGH;
                    st_next.cnt = HIGH_CNT;
                end
            end
            otppv_pkg::S_HIGH: begin
                if (st_reg.cnt == '0) begin
                    if (st_reg.npulse == LAST_PULSE) begin
                        st_next.pins.vpp_en = 1'b0;
                        st_next.fsm = otppv_pkg::S_HOLD;
                        st_next.cnt = HOLD_CNT;
                    end else begin
                        st_next.npulse = st_reg.npulse + 3'h1;
                        st_next.pins.latch_program_pulse_pin = 1'b0;
                        st_next.fsm = otppv_pkg::S_LOW;
                        st_next.cnt = LOW_CNT;
                    end
                end
            end
            otppv_pkg::S_READ: begin
                if (st_reg.cnt == '0) begin
                    st_next.rdata = port0_i;
                    st_next.fsm   = otppv_pkg::S_HOLD;
                    st_next.cnt   = HOLD_CNT;
                end
            end
            otppv_pkg::S_HOLD: begin
                // Address and data held past the last edge, then released
                if (st_reg.cnt == '0) begin
                    st_next.pins = idle_pins(st_next.pins.osc);
                    st_next.fsm  = otppv_pkg::S_IDLE;
                    st_next.done = 1'b1;
                end
            end
            default: begin
                st_next.fsm = otppv_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg         <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready  <= 1'b1;
            st_reg.arready <= 1'b1;
            st_reg.pins    <= idle_pins(1'b0);
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready_o = st_reg.awready;
    assign s_axi_wready_o  = st_reg.wready;
    assign s_axi_bvalid_o  = st_reg.bvalid;
    assign s_axi_bresp_o   = st_reg.bresp;
    assign s_axi_arready_o = st_reg.arready;
    assign s_axi_rvalid_o  = st_reg.rvalid;
    assign s_axi_rdata_o   = st_reg.rdata_bus;
    assign s_axi_rresp_o   = st_reg.rresp;
    assign pins_o          = st_reg.pins;

endmodule

/* File: hw/otppv_pkg.sv */
// Constants, types and pin bundle of the OTP program/verify controller
package otppv_pkg;

    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ    = 125;
    localparam int OSC_KHZ    = 5000;
    localparam int T_SETUP_NS = 12000;
    localparam int T_LOW_NS   = 100000;
    localparam int T_HIGH_NS  = 10000;
    localparam int T_HOLD_NS  = 10000;
    localparam int T_READ_NS  = 12000;
    localparam int OSC_HALF   = (CLK_MHZ * 1000) / (2 * OSC_KHZ);
    localparam int SETUP_CYC  = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int LOW_CYC    = (T_LOW_NS * CLK_MHZ) / 1000;
    localparam int HIGH_CYC   = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC   = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYC   = (T_READ_NS * CLK_MHZ + 999) / 1000;
    localparam int N_PULSES   = 5;
    localparam int CNT_W      = 16;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_WDATA  = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam int         CTRL_GO    = 3;
    localparam int         ST_BUSY    = 0;
    localparam int         ST_DONE    = 1;
    localparam int         ST_RD_LSB  = 8;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;

    // ---------------------------------------------------------------
    // Operations and states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE = 3'h0, OP_CODE = 3'h1, OP_ENC = 3'h2, OP_LOCK1 = 3'h3,
        OP_LOCK2 = 3'h4, OP_LOCK3 = 3'h5, OP_VERIFY = 3'h6, OP_SIG = 3'h7
    } otppv_op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0, S_SETUP = 3'h1, S_LOW = 3'h3, S_HIGH = 3'h2,
        S_HOLD = 3'h6, S_READ = 3'h7
    } otppv_state_t;

    // Device pin levels, all driven from flops
    typedef struct packed {
        logic        dev_rst;
        logic        program_store_strobe;
        logic        latch_program_pulse_pin;
        logic        external_access_supply_pin;
        logic        vpp_en;
        logic        port2_bit7;
        logic        port2_bit6;
        logic        port3_bit7;
        logic        port3_bit6;
        logic [15:0] addr;
        logic [7:0]  port0_out;
        logic        port0_oe;
        logic        osc;
    } otppv_pins_t;

endpackage
